// [logic/arcu_top.sv]
// result computation unit: accumulate, average, burst and low-pass modes with threshold interrupt
`timescale 1ns/1ps
`default_nettype none
`include "arcu_regs.svh"
module arcu_top #(
  parameter int unsigned RES_W = 12,  // converter result width
  parameter int unsigned ACC_W = 18   // accumulator width
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // register port
  input  wire arcu_pkg::arcu_bus_s bus,
  output logic [31:0]            rdata,
  // converter core
  input  wire logic              conv_done,
  input  wire logic [11:0]       conv_result,
  input  wire logic              ext_trig,
  output logic                   conv_start,
  // interrupt
  output logic                   irq
);
  import arcu_pkg::*;

  // the struct fields are fixed, so other widths cannot be served
  if (RES_W != 12) begin : g_bad_res_w
    $error("arcu_top: RES_W must be 12");
  end
  if (ACC_W != 18) begin : g_bad_acc_w
    $error("arcu_top: ACC_W must be 18");
  end

  // count has reached the repeat target
  function automatic logic ge_rpt(input logic [7:0] c, input logic [7:0] r);
    ge_rpt = c >= r;
  endfunction

  // saturating increment of the sample counter
  function automatic logic [7:0] sat_inc(input logic [7:0] c);
    sat_inc = (c == `ARCU_CNT_MAX) ? c : c + 8'h01;
  endfunction

  arcu_state_s        q;         // registered state
  arcu_state_s        n;         // next state
  logic signed [17:0] acc_base;  // accumulator seen by the next sample
  logic [7:0]         cnt_base;  // counter seen by the next sample
  logic signed [12:0] sample;    // value that enters the accumulator
  logic [17:0]        acc_new;   // accumulator after this sample
  logic [17:0]        fltr_new;  // filter value after this sample
  logic               ovf_new;   // this sample overflowed
  logic signed [17:0] err;       // value under threshold test
  logic               thr_hit;   // threshold test verdict

  // operands for the arithmetic, from registered state and the incoming conversion result
  always_comb begin
    // a pending restart makes the next sample begin from empty
    acc_base = q.rst_pend ? 18'sh0_0000 : q.acc;
    cnt_base = q.rst_pend ? 8'h00 : q.cnt;
    // second conversion of a pair contributes its difference, which may be negative
    if (q.cfg.double_sample_en) begin
      sample = $signed({1'b0, conv_result}) - $signed({1'b0, q.res});
    end else begin
      sample = $signed({1'b0, conv_result});
    end
    // basic mode tests the raw sample, others the filter value
    if (q.cfg.mode == ARCU_BASIC) begin
      err = 18'(sample);
    end else begin
      err = fltr_new;
    end
  end

  // accumulator arithmetic
  arcu_calc u_calc (
    .mode     (q.cfg.mode),
    .shift_amount      (q.cfg.shift_amount),
    .acc_in   (acc_base),
    .sample   (sample),
    .acc_out  (acc_new),
    .fltr_out (fltr_new),
    .ovf      (ovf_new)
  );

  // threshold comparison
  arcu_thresh u_thresh (
    .err (err),
    .lth (q.cfg.lth),
    .uth (q.cfg.uth),
    .tmd (q.cfg.tmd),
    .hit (thr_hit)
  );

  logic       start_req;  // software or external start while idle
  logic       sw_go;      // software writes the go bit
  logic       done_ok;    // a conversion completes while running
  logic       cyc_end;    // this completion ends a computation cycle
  logic       test_en;    // threshold test allowed in this cycle
  logic       keep_go;    // conversion request stays up after the cycle
  logic [7:0] cnt_new;    // counter after this cycle
  logic       aov_new;    // overflow bit after this cycle
  logic [2:0] stat_set;   // status events of this cycle

  // next-state logic for the whole unit
  always_comb begin
    n         = q;
    n.rdata   = 32'h0000_0000;
    sw_go     = 1'b0;
    stat_set  = 3'h0;
    cnt_new   = q.cnt;
    aov_new   = q.accum_overflow_bit;
    test_en   = 1'b0;
    keep_go   = q.go;
    done_ok   = conv_done && q.go;
    cyc_end   = done_ok && (!q.cfg.double_sample_en || q.phase);

    // register writes
    if (bus.we) begin
      case (bus.addr)
        `ARCU_ADDR_CTRL: begin
          // unused mode codes fall back to basic
          if (bus.wdata[`ARCU_CTRL_MODE_LSB +: 3] > 3'h4) begin
            n.cfg.mode = ARCU_BASIC;
          end else begin
            n.cfg.mode = arcu_mode_e'(bus.wdata[`ARCU_CTRL_MODE_LSB +: 3]);
          end
          n.cfg.double_sample_en = bus.wdata[`ARCU_CTRL_DOUBLE_SAMPLE_EN];
          n.cfg.continuous_sampling_bit = bus.wdata[`ARCU_CTRL_CONTINUOUS_SAMPLING_BIT];
          n.cfg.shift_amount  = bus.wdata[`ARCU_CTRL_CRS_LSB +: 3];
          n.cfg.tmd  = bus.wdata[`ARCU_CTRL_TMD_LSB +: 3];
          sw_go      = bus.wdata[`ARCU_CTRL_GO];
          // software may abort a running cycle by writing go low
          if (!bus.wdata[`ARCU_CTRL_GO]) begin
            n.go    = 1'b0;
            n.phase = 1'b0;
          end
          if (bus.wdata[`ARCU_CTRL_ACCUM_CLEAR_BIT]) begin
            n.accum_clear_bit = 1'b1;
          end
        end
        `ARCU_ADDR_RPT: n.cfg.rpt = bus.wdata[7:0];
        `ARCU_ADDR_LTH: n.cfg.lth = bus.wdata[17:0];
        `ARCU_ADDR_UTH: n.cfg.uth = bus.wdata[17:0];
        // write one to clear; events below still win
        `ARCU_ADDR_STAT: n.stat = q.stat & ~bus.wdata[2:0];
        `ARCU_ADDR_MASK: n.mask = bus.wdata[2:0];
        default: ;
      endcase
    end

    // a new start arms the request; average and burst may restart from empty
    start_req = (sw_go || ext_trig) && !q.go;
    // the phase is kept, since the second conversion of a pair needs its own start;
    // the mode written together with the go bit is the one in effect for this start
    if (start_req) begin
      n.go = 1'b1;
      if (n.cfg.mode == ARCU_BURST) begin
        n.rst_pend = 1'b1;
      end else if (n.cfg.mode == ARCU_AVG && ge_rpt(q.cnt, q.cfg.rpt)) begin
        n.rst_pend = 1'b1;
      end
    end

    // every finished conversion: shift results, raise flags
    if (done_ok) begin
      n.res  = conv_result;
      n.prev = q.res;
      stat_set[`ARCU_ST_CONV] = 1'b1;
      stat_set[`ARCU_ST_COMPUTATION_DONE_BIT] = 1'b1;
      if (q.cfg.double_sample_en) begin
        n.phase = !q.phase;
      end
      // first of a pair only keeps running in continuous mode
      if (!cyc_end && !q.cfg.continuous_sampling_bit) begin
        n.go = 1'b0;
      end
    end

    // end of a computation cycle
    if (cyc_end) begin
      if (q.cfg.mode == ARCU_BASIC) begin
        // accumulator and count are left alone, test every sample
        test_en = 1'b1;
      end else begin
        n.acc      = acc_new;
        n.fltr     = fltr_new;
        cnt_new    = sat_inc(cnt_base);
        n.cnt      = cnt_new;
        n.rst_pend = 1'b0;
        if (ovf_new) begin
          aov_new = 1'b1;
        end
        n.accum_overflow_bit = aov_new;
        if (q.cfg.mode == ARCU_ACCUM) begin
          test_en = 1'b1;
        end else begin
          test_en = ge_rpt(cnt_new, q.cfg.rpt);
        end
      end
      // burst keeps converting until the target count is in
      keep_go = q.cfg.continuous_sampling_bit || (q.cfg.mode == ARCU_BURST && !ge_rpt(cnt_new, q.cfg.rpt));
      n.go    = keep_go;
      // a continuous retrigger restarts average and burst once the target is met
      if (q.cfg.continuous_sampling_bit && ge_rpt(cnt_new, q.cfg.rpt)) begin
        if (q.cfg.mode == ARCU_AVG || q.cfg.mode == ARCU_BURST) begin
          n.rst_pend = 1'b1;
        end
      end
      // flag only a true test; an overflowed accumulator also signals
      if (test_en && (thr_hit || aov_new)) begin
        stat_set[`ARCU_ST_THR] = 1'b1;
      end
    end

    // software clear takes precedence over a sample landing the same cycle;
    // it completes in one clock, well inside the allowed five
    if (q.accum_clear_bit) begin
      n.acc      = 18'h0_0000;
      n.cnt      = 8'h00;
      n.accum_overflow_bit      = 1'b0;
      n.rst_pend = 1'b0;
      n.accum_clear_bit     = 1'b0;
    end

    // sticky status, set wins over a clear in the same cycle
    n.stat = n.stat | stat_set;
    // level interrupt, registered in the same clock as the status
    n.irq  = |(n.stat & n.mask);

    // register reads, answered in the next cycle only
    if (bus.re) begin
      case (bus.addr)
        `ARCU_ADDR_CTRL: begin
          n.rdata[`ARCU_CTRL_MODE_LSB +: 3] = q.cfg.mode;
          n.rdata[`ARCU_CTRL_DOUBLE_SAMPLE_EN]          = q.cfg.double_sample_en;
          n.rdata[`ARCU_CTRL_CONTINUOUS_SAMPLING_BIT]          = q.cfg.continuous_sampling_bit;
          n.rdata[`ARCU_CTRL_CRS_LSB +: 3]  = q.cfg.shift_amount;
          n.rdata[`ARCU_CTRL_GO]            = q.go;
          n.rdata[`ARCU_CTRL_ACCUM_CLEAR_BIT]          = q.accum_clear_bit;
          n.rdata[`ARCU_CTRL_AOV]           = q.accum_overflow_bit;
          n.rdata[`ARCU_CTRL_TMD_LSB +: 3]  = q.cfg.tmd;
        end
        `ARCU_ADDR_RPT:  n.rdata[7:0]  = q.cfg.rpt;
        `ARCU_ADDR_CNT:  n.rdata[7:0]  = q.cnt;
        `ARCU_ADDR_ACC:  n.rdata[17:0] = q.acc;
        `ARCU_ADDR_FLTR: n.rdata[17:0] = q.fltr;
        `ARCU_ADDR_RES:  n.rdata[11:0] = q.res;
        `ARCU_ADDR_PREV: n.rdata[11:0] = q.prev;
        `ARCU_ADDR_LTH:  n.rdata[17:0] = q.cfg.lth;
        `ARCU_ADDR_UTH:  n.rdata[17:0] = q.cfg.uth;
        `ARCU_ADDR_STAT: n.rdata[2:0]  = q.stat;
        `ARCU_ADDR_MASK: n.rdata[2:0]  = q.mask;
        // unmapped addresses read zero
        default: n.rdata = 32'h0000_0000;
      endcase
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q         <= '0;
      q.cfg.rpt <= `ARCU_RPT_RST;
      q.mask    <= `ARCU_MASK_RST;
    end else begin
      q <= n;
    end
  end

  // outputs straight from the state register
  assign rdata      = q.rdata;
  assign conv_start = q.go;
  assign irq        = q.irq;

endmodule
`default_nettype wire

// [inc/arcu_regs.svh]
// register offsets, field positions, reset values and timing counts of the result computation unit
`ifndef ARCU_REGS_SVH
`define ARCU_REGS_SVH

// word addresses on the register port
`define ARCU_ADDR_CTRL   4'h0
`define ARCU_ADDR_RPT    4'h1
`define ARCU_ADDR_CNT    4'h2
`define ARCU_ADDR_ACC    4'h3
`define ARCU_ADDR_FLTR   4'h4
`define ARCU_ADDR_RES    4'h5
`define ARCU_ADDR_PREV   4'h6
`define ARCU_ADDR_LTH    4'h7
`define ARCU_ADDR_UTH    4'h8
`define ARCU_ADDR_STAT   4'h9
`define ARCU_ADDR_MASK   4'hA

// control word fields
`define ARCU_CTRL_MODE_LSB 0
`define ARCU_CTRL_DOUBLE_SAMPLE_EN     3
`define ARCU_CTRL_CONTINUOUS_SAMPLING_BIT     4
`define ARCU_CTRL_CRS_LSB  5
`define ARCU_CTRL_GO       8
`define ARCU_CTRL_ACCUM_CLEAR_BIT     9
`define ARCU_CTRL_AOV      10
`define ARCU_CTRL_TMD_LSB  11

// status and mask bit positions
`define ARCU_ST_CONV 0
`define ARCU_ST_THR  1
`define ARCU_ST_COMPUTATION_DONE_BIT 2

// reset values and counter ceiling
`define ARCU_RPT_RST  8'h00
`define ARCU_MASK_RST 3'h0
`define ARCU_CNT_MAX  8'hFF

// accumulator clear finishes this many clocks after the request
`define ARCU_ACCUM_CLEAR_BIT_CYCLES 1

`endif

// [inc/arcu_pkg.sv]
// types shared by the result computation unit
package arcu_pkg;

  // computation modes, encoded 0..4 in declaration order
  typedef enum logic [2:0] {
    ARCU_BASIC,
    ARCU_ACCUM,
    ARCU_AVG,
    ARCU_BURST,
    ARCU_LPF
  } arcu_mode_e;

  // register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        we;
    logic        re;
  } arcu_bus_s;

  // software configuration
  typedef struct packed {
    arcu_mode_e  mode;
    logic        double_sample_en;
    logic        continuous_sampling_bit;
    logic [2:0]  shift_amount;
    logic [2:0]  tmd;
    logic [7:0]  rpt;
    logic [17:0] lth;
    logic [17:0] uth;
  } arcu_cfg_s;

  // whole state of the top module
  typedef struct packed {
    arcu_cfg_s   cfg;
    logic        go;
    logic        accum_clear_bit;
    logic        accum_overflow_bit;
    logic        phase;
    logic        rst_pend;
    logic [7:0]  cnt;
    logic [17:0] acc;
    logic [17:0] fltr;
    logic [11:0] res;
    logic [11:0] prev;
    logic [2:0]  stat;
    logic [2:0]  mask;
    logic        irq;
    logic [31:0] rdata;
  } arcu_state_s;

endpackage

// [logic/arcu_calc.sv]
// accumulator arithmetic: accumulate or low-pass step, overflow and shifted filter value
`timescale 1ns/1ps
`default_nettype none
module arcu_calc (
  // operation select
  input  wire arcu_pkg::arcu_mode_e mode,
  input  wire logic [2:0]           shift_amount,
  // operands
  input  wire logic signed [17:0]   acc_in,
  input  wire logic signed [12:0]   sample,
  // results
  output logic [17:0]               acc_out,
  output logic [17:0]               fltr_out,
  output logic                      ovf
);
  import arcu_pkg::*;

  // arithmetic right shift, kept signed so negative sums divide toward minus
  function automatic logic signed [19:0] shr(input logic signed [19:0] v, input logic [2:0] s);
    shr = v >>> s;
  endfunction

  logic signed [19:0] base;  // accumulator widened for carry detection
  logic signed [19:0] sum;   // new accumulator before truncation

  // one adder path; low-pass subtracts the decayed part of the old value
  always_comb begin
    // the stored word counts up through the full 18-bit range before it overflows;
    // differences below zero still wrap correctly in two's complement
    base = {2'b00, acc_in};
    if (mode == ARCU_LPF) begin
      sum = {{7{sample[12]}}, sample} + base - shr(base, shift_amount);
    end else begin
      sum = {{7{sample[12]}}, sample} + base;
    end
    ovf      = (sum > 20'sd262143) || (sum < -20'sd262144);
    acc_out  = sum[17:0];
    fltr_out = 18'(shr({{2{sum[17]}}, sum[17:0]}, shift_amount));
  end
endmodule
`default_nettype wire

// [logic/arcu_thresh.sv]
// signed threshold test on the computed error
`timescale 1ns/1ps
`default_nettype none
module arcu_thresh (
  // operands
  input  wire logic signed [17:0] err,
  input  wire logic signed [17:0] lth,
  input  wire logic signed [17:0] uth,
  // test select
  input  wire logic [2:0]         tmd,
  // verdict
  output logic                    hit
);
  // all comparisons signed, eight test kinds
  always_comb begin
    case (tmd)
      3'h0: hit = 1'b0;
      3'h1: hit = err < lth;
      3'h2: hit = err >= lth;
      3'h3: hit = (err >= lth) && (err <= uth);
      3'h4: hit = (err < lth) || (err > uth);
      3'h5: hit = err <= uth;
      3'h6: hit = err > uth;
      default: hit = 1'b1;
    endcase
  end
endmodule
`default_nettype wire

// [test/arcu_top_chk.sv]
// port assertions for the result computation unit
`timescale 1ns/1ps
`default_nettype none
`include "arcu_regs.svh"
module arcu_top_chk (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst,
  // register port
  input  wire arcu_pkg::arcu_bus_s bus,
  input  wire logic [31:0]         rdata,
  // converter core
  input  wire logic                conv_done,
  input  wire logic [11:0]         conv_result,
  input  wire logic                ext_trig,
  input  wire logic                conv_start,
  // interrupt
  input  wire logic                irq
);
  import arcu_pkg::*;
  logic [4:0] ctl_q; // shadow of mode, double sample and continuous bits
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // only software changes these bits, so a write shadow is exact apart from mode codes above 4, which the unit stores as basic
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctl_q <= 5'h00;
    end else if (bus.we && bus.addr == `ARCU_ADDR_CTRL) begin
      ctl_q <= bus.wdata[4:0];
    end
  end
  AST_RDATA_IDLE: assert property (!$past(bus.re) |-> rdata == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  AST_START_HOLD: assert property (conv_start && !conv_done && !bus.we |=> conv_start)
    else $error("conversion request dropped mid conversion");
  AST_START_DROP: assert property (conv_start && conv_done && !bus.we && ctl_q[4:3] == 2'b00 &&
    ctl_q[2:0] != 3'h3 |=> !conv_start)
    else $error("request not cleared after single conversion");
  AST_CONTINUOUS_SAMPLING_BIT_HOLD: assert property (conv_start && conv_done && ctl_q[4] && !bus.we |=> conv_start)
    else $error("continuous request cleared on completion");
  AST_TRIG_START: assert property (!conv_start && ext_trig && !bus.we |=> conv_start)
    else $error("external start ignored");
  AST_IRQ_RISE: assert property ($rose(irq) |-> ($past(conv_done) && $past(conv_start)) ||
    $past(bus.we))
    else $error("interrupt rose without a cause");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(bus.we))
    else $error("interrupt fell without a write");
  AST_ACC_CLR: assert property ((bus.we && bus.addr == `ARCU_ADDR_CTRL && bus.wdata[9] && !conv_done) ##1
    !conv_done ##1 (bus.re && bus.addr == `ARCU_ADDR_ACC && !conv_done) |=> rdata == 32'h0000_0000)
    else $error("accumulator not cleared by clear bit");
  AST_MODE_READ: assert property ((bus.we && bus.addr == `ARCU_ADDR_CTRL && bus.wdata[2:0] <= 3'h4) ##1
    !bus.we ##1 (bus.re && bus.addr == `ARCU_ADDR_CTRL) |=> rdata[2:0] == $past(bus.wdata[2:0], 3))
    else $error("mode field reads back wrong");
endmodule
`default_nettype wire

// [test/arcu_core_model.sv]
// behavioural converter core feeding the computation unit
`timescale 1ns/1ps
`default_nettype none
module arcu_core_model (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // request and bench settings
  input  wire logic        conv_start,
  input  wire logic [3:0]  dly,
  input  wire logic [11:0] sample,
  // answer
  output logic             conv_done,
  output logic [11:0]      conv_result
);
  logic [3:0] wait_q; // cycles spent on the current conversion
  // one conversion takes dly+1 cycles; the result toggles outside the pulse so stale data never matches
  always_ff @(posedge sys_clk) begin
    conv_result <= ~conv_result;
    if (rst || !conv_start || conv_done) begin
      wait_q    <= 4'h0;
      conv_done <= 1'b0;
    end else if (wait_q >= dly) begin
      wait_q      <= 4'h0;
      conv_done   <= 1'b1;
      conv_result <= sample;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

// [test/tb.sv]
// self-checking bench for the result computation unit
`timescale 1ns/1ps
`default_nettype none
`include "arcu_regs.svh"
module tb;
  import arcu_pkg::*;
  logic        sys_clk  = 1'b0;     // 100 MHz clock
  logic        rst      = 1'b1;     // synchronous reset
  arcu_bus_s   bus      = '0;       // register request
  logic [31:0] rdata;               // read answer
  logic        conv_done;           // completion from model
  logic [11:0] conv_result;         // result from model
  logic        ext_trig = 1'b0;     // external start
  logic        conv_start;          // conversion request
  logic        irq;                 // interrupt level
  logic [11:0] smp      = 12'h000;  // next converted value
  logic [3:0]  dly      = 4'h1;     // model latency
  int          fails    = 0;        // mismatches
  int          num_checks = 0;      // comparisons
  int          i;                   // loop index
  always #5 sys_clk = ~sys_clk;
  arcu_top arcu_top_i (.sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata(rdata), .conv_done(conv_done),
    .conv_result(conv_result), .ext_trig(ext_trig), .conv_start(conv_start), .irq(irq));
  arcu_core_model arcu_core_model_i (.sys_clk(sys_clk), .rst(rst), .conv_start(conv_start), .dly(dly),
    .sample(smp), .conv_done(conv_done), .conv_result(conv_result));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // write, then one idle cycle so strobes never double up
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge sys_clk);
    bus.we <= 1'b0;
    @(posedge sys_clk);
  endtask
  // read; the answer stands only in the next cycle
  task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
    bus <= '{addr: a, wdata: 32'h0000_0000, we: 1'b0, re: 1'b1};
    @(posedge sys_clk);
    bus.re <= 1'b0;
    @(negedge sys_clk);
    chk(rdata, exp);
    @(posedge sys_clk);
  endtask
  // interrupt level, sampled away from the edge
  task automatic ichk(input logic e);
    @(negedge sys_clk);
    chk({31'h0, irq}, {31'h0, e});
    @(posedge sys_clk);
  endtask
  task automatic accum_clear_bit();
    wr(`ARCU_ADDR_CTRL, 32'h0000_0200);
  endtask
  // control word: mode, double sample, continuous, shift, go, threshold test
  function automatic logic [31:0] ctl(input logic [2:0] m, input logic ds, input logic ct,
                                      input logic [2:0] shift_amount, input logic go, input logic [2:0] tmd);
    return {18'h0_0000, tmd, 2'b00, go, shift_amount, ct, ds, m};
  endfunction
  // one start by software or by the external pin, waited on until the conversion request drops
  task automatic conv(input logic [11:0] s, input logic [31:0] c, input logic trig);
    int n;
    n = 0;
    smp <= s;
    if (trig) begin
      ext_trig <= 1'b1;
      @(posedge sys_clk);
      ext_trig <= 1'b0;
      @(posedge sys_clk);
    end else begin
      wr(`ARCU_ADDR_CTRL, c | 32'h0000_0100);
    end
    do begin
      @(negedge sys_clk);
      n++;
    end while (conv_start === 1'b1 && n < 80);
    if (n >= 80) chk(32'h0000_0001, 32'h0000_0000);
    @(posedge sys_clk);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // tests take about 2000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    $display("FAIL t=%0t watchdog expired", $time);
    final_report();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rchk(`ARCU_ADDR_RPT, 32'h0000_0000);
    rchk(`ARCU_ADDR_MASK, 32'h0000_0000);
    rchk(`ARCU_ADDR_CNT, 32'h0000_0000);
    rchk(`ARCU_ADDR_CTRL, 32'h0000_0000);
    rchk(4'hF, 32'h0000_0000);
    ichk(1'b0);
    $display("test reset done");
    for (i = 1; i <= 6; i++) begin
      accum_clear_bit();
      conv(12'hFC0, ctl(3'h1, 1'b0, 1'b0, i[2:0], 1'b0, 3'h0), 1'b0);
      rchk(`ARCU_ADDR_FLTR, 32'h0000_0FC0 >> i);
    end
    accum_clear_bit();
    conv(12'h064, ctl(3'h1, 1'b0, 1'b0, 3'h1, 1'b0, 3'h0), 1'b0);
    conv(12'h12C, ctl(3'h1, 1'b0, 1'b0, 3'h1, 1'b0, 3'h0), 1'b0);
    rchk(`ARCU_ADDR_ACC, 32'h0000_0190);
    rchk(`ARCU_ADDR_CNT, 32'h0000_0002);
    rchk(`ARCU_ADDR_FLTR, 32'h0000_00C8);
    rchk(`ARCU_ADDR_STAT, 32'h0000_0005);
    rchk(`ARCU_ADDR_CTRL, 32'h0000_0021);
    accum_clear_bit();
    rchk(`ARCU_ADDR_ACC, 32'h0000_0000);
    rchk(`ARCU_ADDR_CNT, 32'h0000_0000);
    rchk(`ARCU_ADDR_CTRL, 32'h0000_0000);
    $display("test accumulate done");
    wr(`ARCU_ADDR_STAT, 32'h0000_0007);
    conv(12'h04D, ctl(3'h0, 1'b0, 1'b0, 3'h0, 1'b0, 3'h7), 1'b0);
    rchk(`ARCU_ADDR_ACC, 32'h0000_0000);
    rchk(`ARCU_ADDR_CNT, 32'h0000_0000);
    rchk(`ARCU_ADDR_STAT, 32'h0000_0007);
    rchk(`ARCU_ADDR_RES, 32'h0000_004D);
    ichk(1'b0);
    wr(`ARCU_ADDR_MASK, 32'h0000_0002);
    ichk(1'b1);
    wr(`ARCU_ADDR_STAT, 32'h0000_0002);
    rchk(`ARCU_ADDR_STAT, 32'h0000_0005);
    ichk(1'b0);
    wr(`ARCU_ADDR_MASK, 32'h0000_0000);
    wr(`ARCU_ADDR_LTH, 32'h0000_0050);
    wr(`ARCU_ADDR_UTH, 32'h0000_0060);
    rchk(`ARCU_ADDR_LTH, 32'h0000_0050);
    rchk(`ARCU_ADDR_UTH, 32'h0000_0060);
    wr(`ARCU_ADDR_STAT, 32'h0000_0007);
    conv(12'h04D, ctl(3'h0, 1'b0, 1'b0, 3'h0, 1'b0, 3'h6), 1'b0);
    rchk(`ARCU_ADDR_STAT, 32'h0000_0005);
    conv(12'h04D, ctl(3'h0, 1'b0, 1'b0, 3'h0, 1'b0, 3'h1), 1'b0);
    rchk(`ARCU_ADDR_STAT, 32'h0000_0007);
    wr(`ARCU_ADDR_CTRL, 32'h0000_0007);
    rchk(`ARCU_ADDR_CTRL, 32'h0000_0000);
    $display("test basic done");
    wr(`ARCU_ADDR_RPT, 32'h0000_0002);
    accum_clear_bit();
    wr(`ARCU_ADDR_STAT, 32'h0000_0007);
    conv(12'h00A, ctl(3'h2, 1'b0, 1'b0, 3'h0, 1'b0, 3'h7), 1'b0);
    rchk(`ARCU_ADDR_STAT, 32'h0000_0005);
    conv(12'h014, ctl(3'h2, 1'b0, 1'b0, 3'h0, 1'b0, 3'h7), 1'b0);
    rchk(`ARCU_ADDR_STAT, 32'h0000_0007);
    rchk(`ARCU_ADDR_ACC, 32'h0000_001E);
    conv(12'h005, ctl(3'h2, 1'b0, 1'b0, 3'h0, 1'b0, 3'h7), 1'b0);
    rchk(`ARCU_ADDR_ACC, 32'h0000_0005);
    rchk(`ARCU_ADDR_CNT, 32'h0000_0001);
    wr(`ARCU_ADDR_RPT, 32'h0000_0003);
    conv(12'h028, ctl(3'h3, 1'b0, 1'b0, 3'h0, 1'b0, 3'h7), 1'b0);
    rchk(`ARCU_ADDR_ACC, 32'h0000_0078);
    rchk(`ARCU_ADDR_CNT, 32'h0000_0003);
    $display("test average and burst done");
    accum_clear_bit();
    wr(`ARCU_ADDR_RPT, 32'h0000_0001);
    conv(12'h064, ctl(3'h4, 1'b0, 1'b0, 3'h1, 1'b0, 3'h7), 1'b0);
    rchk(`ARCU_ADDR_ACC, 32'h0000_0064);
    conv(12'h064, ctl(3'h4, 1'b0, 1'b0, 3'h1, 1'b0, 3'h7), 1'b0);
    rchk(`ARCU_ADDR_ACC, 32'h0000_0096);
    rchk(`ARCU_ADDR_FLTR, 32'h0000_004B);
    dly <= 4'h7;
    accum_clear_bit();
    wr(`ARCU_ADDR_STAT, 32'h0000_0007);
    conv(12'h1F4, ctl(3'h1, 1'b1, 1'b0, 3'h0, 1'b0, 3'h7), 1'b0);
    rchk(`ARCU_ADDR_STAT, 32'h0000_0005);
    rchk(`ARCU_ADDR_ACC, 32'h0000_0000);
    conv(12'h0C8, ctl(3'h1, 1'b1, 1'b0, 3'h0, 1'b0, 3'h7), 1'b0);
    rchk(`ARCU_ADDR_ACC, 32'h0003_FED4);
    rchk(`ARCU_ADDR_PREV, 32'h0000_01F4);
    rchk(`ARCU_ADDR_STAT, 32'h0000_0007);
    dly <= 4'h1;
    $display("test filter and double sample done");
    accum_clear_bit();
    wr(`ARCU_ADDR_STAT, 32'h0000_0007);
    for (i = 0; i < 65; i++) conv(12'hFFF, ctl(3'h1, 1'b0, 1'b0, 3'h0, 1'b0, 3'h0), 1'b0);
    rchk(`ARCU_ADDR_CTRL, 32'h0000_0401);
    rchk(`ARCU_ADDR_ACC, 32'h0000_0FBF);
    rchk(`ARCU_ADDR_STAT, 32'h0000_0007);
    wr(`ARCU_ADDR_CTRL, 32'h0000_0201);
    rchk(`ARCU_ADDR_CTRL, 32'h0000_0001);
    $display("test overflow done");
    smp <= 12'h001;
    wr(`ARCU_ADDR_CTRL, ctl(3'h1, 1'b0, 1'b1, 3'h0, 1'b1, 3'h0));
    repeat (20) @(posedge sys_clk);
    wr(`ARCU_ADDR_CTRL, ctl(3'h1, 1'b0, 1'b0, 3'h0, 1'b0, 3'h0));
    accum_clear_bit();
    for (i = 0; i < 256; i++) conv(12'h001, ctl(3'h1, 1'b0, 1'b0, 3'h0, 1'b0, 3'h0), 1'b0);
    rchk(`ARCU_ADDR_CNT, 32'h0000_00FF);
    conv(12'h001, 32'h0000_0000, 1'b1);
    rchk(`ARCU_ADDR_CNT, 32'h0000_00FF);
    rchk(`ARCU_ADDR_ACC, 32'h0000_0101);
    $display("test saturation done");
    final_report();
  end
endmodule
bind arcu_top arcu_top_chk arcu_top_chk_i (.sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata(rdata),
  .conv_done(conv_done), .conv_result(conv_result), .ext_trig(ext_trig), .conv_start(conv_start), .irq(irq));
`default_nettype wire
